// ===== hdl/wtp_regs.svh
// register offsets, field positions and fixed values of the wide timer
// assumes: included by bare name from hdl files
`ifndef WTP_REGS_SVH
`define WTP_REGS_SVH

// apb byte offsets
`define WTP_OFS_CTRL   8'h00
`define WTP_OFS_COUNT  8'h04
`define WTP_OFS_CMPA   8'h08
`define WTP_OFS_CMPB   8'h0C
`define WTP_OFS_CAPT   8'h10
`define WTP_OFS_FLAGS  8'h14
`define WTP_OFS_STAT   8'h18

// control field positions
`define WTP_CTRL_MODE  0
`define WTP_CTRL_ACTA  4
`define WTP_CTRL_ACTB  6
`define WTP_CTRL_PSC   8
`define WTP_CTRL_DIRA  12
`define WTP_CTRL_DIRB  13
`define WTP_CTRL_RST   14'h0000

// flag bit positions
`define WTP_FLG_OVF    0
`define WTP_FLG_PRI    1
`define WTP_FLG_CHB    2
`define WTP_FLG_CAP    3

// waveform mode select codes
`define WTP_MODE_CTCA  4'h4
`define WTP_MODE_CTCI  4'hC
`define WTP_MODE_PWM8  4'h5
`define WTP_MODE_PWM9  4'h6
`define WTP_MODE_PWM10 4'h7
`define WTP_MODE_PWMI  4'hE
`define WTP_MODE_PWMA  4'hF

// fixed tops and counter limits
`define WTP_TOP_8      16'h00FF
`define WTP_TOP_9      16'h01FF
`define WTP_TOP_10     16'h03FF
`define WTP_MAX        16'hFFFF
`define WTP_BOTTOM     16'h0000

// output action codes
`define WTP_ACT_NONE   2'h0
`define WTP_ACT_TOGL   2'h1
`define WTP_ACT_TWO    2'h2
`define WTP_ACT_THREE  2'h3

// prescaler select codes: 0 stop, 1..5 divide by 1, 8, 64, 256, 1024
`define WTP_PSC_OFF    3'h0
`define WTP_PSC_1      3'h1
`define WTP_PSC_8      3'h2
`define WTP_PSC_64     3'h3
`define WTP_PSC_256    3'h4
`define WTP_PSC_1024   3'h5

`endif

// ===== hdl/wtp_pkg.sv
// types shared by the wide timer files
// assumes: compiled before any wide timer module
`default_nettype none
package wtp_pkg;
    // counting class derived from the mode select
    typedef enum logic [1:0] {
        WTP_CLS_FREE,   // unsupported modes, plain wrap
        WTP_CLS_CTC,    // clear on match
        WTP_CLS_PWM     // single-slope fast pwm
    } wtp_cls_t;
endpackage
`default_nettype wire

// ===== hdl/wtp_channel.sv
// one compare output unit: waveform level of one channel
// assumes: tick, match and top_hit come from the counter on pclk
`default_nettype none
`include "wtp_regs.svh"
module wtp_channel
    import wtp_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       tick,       // prescaled timer step
    input  wire logic       match,      // counter equals compare
    input  wire logic       top_hit,    // pwm top reached on a tick
    input  wire wtp_cls_t   cls,        // counting class
    input  wire logic [1:0] action,     // channel_output_action
    input  wire logic       toggle_en,  // toggle allowed in this mode
    output logic            wave        // channel_wave_output level
);
    logic wave_q;   // waveform state
    logic wave_d;   // next waveform state

    ////////////////////////////////////////////////////////////////////
    // next level; action read live so a new one acts at next match
    always_comb begin
        wave_d = wave_q;
        if (tick) begin
            if (cls == WTP_CLS_PWM) begin
                // restart edge first, match below overrides it
                if (top_hit) begin
                    if (action == `WTP_ACT_TWO) begin
                        wave_d = 1'b0;
                    end else if (action == `WTP_ACT_THREE) begin
                        wave_d = 1'b1;
                    end
                end
                // match beats top so compare == top holds a level
                if (match) begin
                    case (action)
                        `WTP_ACT_TOGL:  wave_d = toggle_en ? ~wave_q : wave_q;
                        `WTP_ACT_TWO:   wave_d = 1'b1;
                        `WTP_ACT_THREE: wave_d = 1'b0;
                        default:        wave_d = wave_q;
                    endcase
                end
            end else if (cls == WTP_CLS_CTC && match) begin
                case (action)
                    `WTP_ACT_TOGL:  wave_d = toggle_en ? ~wave_q : wave_q;
                    `WTP_ACT_TWO:   wave_d = 1'b0;
                    `WTP_ACT_THREE: wave_d = 1'b1;
                    default:        wave_d = wave_q;
                endcase
            end
        end
    end

    // waveform register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wave_q <= 1'b0;
        end else begin
            wave_q <= wave_d;
        end
    end

    assign wave = wave_q;

    ////////////////////////////////////////////////////////////////////
    // toggle action inverts the level on a ctc match
    property p_ctc_toggle;
        @(posedge pclk) disable iff (!presetn)
        (tick && match && cls == WTP_CLS_CTC && action == `WTP_ACT_TOGL && toggle_en)
            |=> (wave_q != $past(wave_q));
    endproperty
    a_ctc_toggle: assert property (p_ctc_toggle)
        else $error("ctc toggle did not invert the output");

    // action none leaves the level unchanged
    property p_no_action;
        @(posedge pclk) disable iff (!presetn)
        (action == `WTP_ACT_NONE) |=> $stable(wave_q);
    endproperty
    a_no_action: assert property (p_no_action)
        else $error("output changed with action none");
endmodule
`default_nettype wire

// ===== hdl/wtp_top.sv
// wide timer waveform block: ctc and fast pwm with apb registers
// assumes: apb master on pclk, pins driven through the wave ports
`default_nettype none
`include "wtp_regs.svh"
module wtp_top
    import wtp_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             primary_wave_output,
    output logic             primary_wave_oe,
    output logic             channel_wave_output,
    output logic             channel_wave_oe
);
    ////////////////////////////////////////////////////////////////////
    // declarations
    logic [13:0] ctrl_q;        // control word
    logic [15:0] cnt_q;         // wide_counter_value
    logic [15:0] cnt_d;         // next count
    logic [15:0] cmpa_buf_q;    // primary compare buffer
    logic [15:0] cmpa_act_q;    // active primary_compare_value
    logic [15:0] cmpb_buf_q;    // channel compare buffer
    logic [15:0] cmpb_act_q;    // active channel_compare_value
    logic [15:0] capt_q;        // capture_top_register
    logic [3:0]  flag_q;        // sticky flags
    logic [3:0]  flag_set;      // hardware set terms
    logic [31:0] prdata_q;      // registered read data
    logic [9:0]  psc_q;         // prescaler count
    logic        tick;          // prescaled timer step
    logic [3:0]  mode;          // waveform_mode_select
    wtp_cls_t    cls;           // counting class
    logic [15:0] top;           // current top
    logic        at_top;        // count equals top
    logic        top_hit;       // pwm top on a tick
    logic        match_a;       // primary compare match
    logic        match_b;       // channel compare match
    logic        wave_a;        // primary waveform state
    logic        wave_b;        // channel waveform state
    logic        wr_en;         // apb write strobe
    logic        rd_setup;      // apb read setup phase
    logic        mapped;        // address decodes

    ////////////////////////////////////////////////////////////////////
    // helpers
    // top value per mode
    function automatic logic [15:0] top_of(input logic [3:0]  m,
                                           input logic [15:0] ca,
                                           input logic [15:0] ic);
        if (m == `WTP_MODE_CTCA || m == `WTP_MODE_PWMA) begin
            top_of = ca;
        end else if (m == `WTP_MODE_CTCI || m == `WTP_MODE_PWMI) begin
            top_of = ic;
        end else if (m == `WTP_MODE_PWM8) begin
            top_of = `WTP_TOP_8;
        end else if (m == `WTP_MODE_PWM9) begin
            top_of = `WTP_TOP_9;
        end else if (m == `WTP_MODE_PWM10) begin
            top_of = `WTP_TOP_10;
        end else begin
            top_of = `WTP_MAX;
        end
    endfunction

    // compare write masked to a fixed top width
    function automatic logic [15:0] mask_cmp(input logic [3:0]  m,
                                             input logic [15:0] v);
        if (m == `WTP_MODE_PWM8) begin
            mask_cmp = v & `WTP_TOP_8;
        end else if (m == `WTP_MODE_PWM9) begin
            mask_cmp = v & `WTP_TOP_9;
        end else if (m == `WTP_MODE_PWM10) begin
            mask_cmp = v & `WTP_TOP_10;
        end else begin
            mask_cmp = v;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // mode decode
    assign mode = ctrl_q[`WTP_CTRL_MODE +: 4];

    // class from mode select
    always_comb begin
        if (mode == `WTP_MODE_CTCA || mode == `WTP_MODE_CTCI) begin
            cls = WTP_CLS_CTC;
        end else if (mode == `WTP_MODE_PWM8 || mode == `WTP_MODE_PWM9 ||
                     mode == `WTP_MODE_PWM10 || mode == `WTP_MODE_PWMI ||
                     mode == `WTP_MODE_PWMA) begin
            cls = WTP_CLS_PWM;
        end else begin
            cls = WTP_CLS_FREE;
        end
    end

    // top and compare events; any 16-bit register top allowed
    assign top     = top_of(mode, cmpa_act_q, capt_q);
    assign at_top  = (cnt_q == top);
    assign top_hit = tick && cls == WTP_CLS_PWM && at_top;
    assign match_a = (cnt_q == cmpa_act_q);
    assign match_b = (cnt_q == cmpb_act_q);

    ////////////////////////////////////////////////////////////////////
    // prescaler: free count, tick on divider terminal
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            psc_q <= 10'h000;
        end else begin
            psc_q <= psc_q + 10'h001;
        end
    end

    // tick select
    always_comb begin
        case (ctrl_q[`WTP_CTRL_PSC +: 3])
            `WTP_PSC_1:    tick = 1'b1;
            `WTP_PSC_8:    tick = (psc_q[2:0] == 3'h7);
            `WTP_PSC_64:   tick = (psc_q[5:0] == 6'h3F);
            `WTP_PSC_256:  tick = (psc_q[7:0] == 8'hFF);
            `WTP_PSC_1024: tick = (psc_q == 10'h3FF);
            default:       tick = 1'b0; // stopped
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // apb decode; zero wait states
    assign wr_en    = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign pready   = 1'b1;
    assign prdata   = prdata_q;

    // address map check
    always_comb begin
        if (paddr == `WTP_OFS_CTRL || paddr == `WTP_OFS_COUNT) begin
            mapped = 1'b1;
        end else if (paddr == `WTP_OFS_CMPA || paddr == `WTP_OFS_CMPB) begin
            mapped = 1'b1;
        end else if (paddr == `WTP_OFS_CAPT || paddr == `WTP_OFS_FLAGS) begin
            mapped = 1'b1;
        end else if (paddr == `WTP_OFS_STAT) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end
    assign pslverr = psel && penable && !mapped;

    // read data captured in the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (rd_setup) begin
            if (paddr == `WTP_OFS_CTRL) begin
                prdata_q <= {18'h00000, ctrl_q};
            end else if (paddr == `WTP_OFS_COUNT) begin
                prdata_q <= {16'h0000, cnt_q};
            end else if (paddr == `WTP_OFS_CMPA) begin
                prdata_q <= {16'h0000, cmpa_buf_q};
            end else if (paddr == `WTP_OFS_CMPB) begin
                prdata_q <= {16'h0000, cmpb_buf_q};
            end else if (paddr == `WTP_OFS_CAPT) begin
                prdata_q <= {16'h0000, capt_q};
            end else if (paddr == `WTP_OFS_FLAGS) begin
                prdata_q <= {28'h0000000, flag_q};
            end else if (paddr == `WTP_OFS_STAT) begin
                prdata_q <= {30'h00000000, wave_b, wave_a};
            end else begin
                prdata_q <= 32'h0000_0000; // unmapped
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `WTP_CTRL_RST;
        end else if (wr_en && paddr == `WTP_OFS_CTRL) begin
            ctrl_q <= pwdata[13:0];
        end
    end

    // capture register written directly, acts as top at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capt_q <= `WTP_BOTTOM;
        end else if (wr_en && paddr == `WTP_OFS_CAPT) begin
            capt_q <= pwdata[15:0];
        end
    end

    // compare buffers take software writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmpa_buf_q <= `WTP_BOTTOM;
            cmpb_buf_q <= `WTP_BOTTOM;
        end else if (wr_en && paddr == `WTP_OFS_CMPA) begin
            cmpa_buf_q <= mask_cmp(mode, pwdata[15:0]);
        end else if (wr_en && paddr == `WTP_OFS_CMPB) begin
            cmpb_buf_q <= mask_cmp(mode, pwdata[15:0]);
        end
    end

    // active compares: copied at top in pwm, follow buffer otherwise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmpa_act_q <= `WTP_BOTTOM;
            cmpb_act_q <= `WTP_BOTTOM;
        end else if (cls != WTP_CLS_PWM) begin
            cmpa_act_q <= cmpa_buf_q;
            cmpb_act_q <= cmpb_buf_q;
        end else if (top_hit) begin
            cmpa_act_q <= cmpa_buf_q;
            cmpb_act_q <= cmpb_buf_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // counter next value
    always_comb begin
        cnt_d = cnt_q;
        if (wr_en && paddr == `WTP_OFS_COUNT) begin
            cnt_d = pwdata[15:0];
        end else if (tick) begin
            if (cls != WTP_CLS_FREE && at_top) begin
                cnt_d = `WTP_BOTTOM;
            end else begin
                cnt_d = cnt_q + 16'h0001;
            end
        end
    end

    // counter register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= `WTP_BOTTOM;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // flag set terms, all on ticks
    always_comb begin
        flag_set = 4'h0;
        if (tick) begin
            if (cls == WTP_CLS_PWM) begin
                flag_set[`WTP_FLG_OVF] = at_top;
            end else begin
                flag_set[`WTP_FLG_OVF] = (cnt_q == `WTP_MAX);
            end
            flag_set[`WTP_FLG_PRI] = match_a;
            flag_set[`WTP_FLG_CHB] = match_b;
            if (mode == `WTP_MODE_CTCI || mode == `WTP_MODE_PWMI) begin
                flag_set[`WTP_FLG_CAP] = at_top;
            end
        end
    end

    // sticky flags, write one clears, set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= 4'h0;
        end else if (wr_en && paddr == `WTP_OFS_FLAGS) begin
            flag_q <= (flag_q & ~pwdata[3:0]) | flag_set;
        end else begin
            flag_q <= flag_q | flag_set;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // compare output units
    wtp_channel u_chan_a (
        .pclk      (pclk),
        .presetn   (presetn),
        .tick      (tick),
        .match     (match_a),
        .top_hit   (top_hit),
        .cls       (cls),
        .action    (ctrl_q[`WTP_CTRL_ACTA +: 2]),
        .toggle_en (cls == WTP_CLS_CTC || mode == `WTP_MODE_PWMA),
        .wave      (wave_a)
    );

    wtp_channel u_chan_b (
        .pclk      (pclk),
        .presetn   (presetn),
        .tick      (tick),
        .match     (match_b),
        .top_hit   (top_hit),
        .cls       (cls),
        .action    (ctrl_q[`WTP_CTRL_ACTB +: 2]),
        .toggle_en (cls == WTP_CLS_CTC),
        .wave      (wave_b)
    );

    // pin gating by direction bits
    assign primary_wave_oe     = ctrl_q[`WTP_CTRL_DIRA];
    assign channel_wave_oe     = ctrl_q[`WTP_CTRL_DIRB];
    assign primary_wave_output = wave_a & ctrl_q[`WTP_CTRL_DIRA];
    assign channel_wave_output = wave_b & ctrl_q[`WTP_CTRL_DIRB];

    ////////////////////////////////////////////////////////////////////
    // checks
    property p_ctc_clear;
        @(posedge pclk) disable iff (!presetn)
        (tick && mode == `WTP_MODE_CTCA && cnt_q == cmpa_act_q &&
         !(wr_en && paddr == `WTP_OFS_COUNT)) |=> (cnt_q == 16'h0000);
    endproperty
    a_ctc_clear: assert property (p_ctc_clear)
        else $error("ctc counter did not clear at top");

    property p_ctc_ovf;
        @(posedge pclk) disable iff (!presetn)
        (tick && cls == WTP_CLS_CTC && cnt_q == 16'hFFFF) |=> flag_q[0];
    endproperty
    a_ctc_ovf: assert property (p_ctc_ovf)
        else $error("ctc overflow flag missing after wrap");

    property p_pwm_top_flags;
        @(posedge pclk) disable iff (!presetn)
        (top_hit && mode == `WTP_MODE_PWMA) |=> (flag_q[0] && flag_q[1]);
    endproperty
    a_pwm_top_flags: assert property (p_pwm_top_flags)
        else $error("pwm top did not set overflow and primary flags");

    property p_buf_copy;
        @(posedge pclk) disable iff (!presetn)
        top_hit |=> (cmpa_act_q == $past(cmpa_buf_q));
    endproperty
    a_buf_copy: assert property (p_buf_copy)
        else $error("primary compare not copied at top");

    property p_match_flag;
        @(posedge pclk) disable iff (!presetn)
        (tick && match_b) |=> flag_q[2];
    endproperty
    a_match_flag: assert property (p_match_flag)
        else $error("channel match flag not set");

    property p_pin_gate;
        @(posedge pclk) disable iff (!presetn)
        !ctrl_q[12] |-> (!primary_wave_output && !primary_wave_oe);
    endproperty
    a_pin_gate: assert property (p_pin_gate)
        else $error("primary wave visible with direction clear");

    property p_tick_hold;
        @(posedge pclk) disable iff (!presetn)
        (!tick && !(wr_en && paddr == `WTP_OFS_COUNT)) |=> $stable(cnt_q);
    endproperty
    a_tick_hold: assert property (p_tick_hold)
        else $error("counter moved without a tick");

    property p_pwm_step;
        @(posedge pclk) disable iff (!presetn)
        (tick && cls == WTP_CLS_PWM && !at_top && !(wr_en && paddr == `WTP_OFS_COUNT))
            |=> (cnt_q == $past(cnt_q) + 16'h0001);
    endproperty
    a_pwm_step: assert property (p_pwm_step)
        else $error("pwm counter did not step by one");

    property p_mask;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == `WTP_OFS_CMPB && mode == `WTP_MODE_PWM8)
            |=> (cmpb_buf_q[15:8] == 8'h00);
    endproperty
    a_mask: assert property (p_mask)
        else $error("compare write not masked to fixed top");
endmodule
`default_nettype wire

// ===== bench/wtp_pin_model.sv
// port pin model: the level seen outside the timer
// assumes: oe and data come from the timer on pclk
`default_nettype none
module wtp_pin_model (
    input  wire logic pclk,
    input  wire logic oe,
    input  wire logic data,
    output logic      pin
);
    timeunit 1ns;
    timeprecision 100ps;
    logic last_q = 1'b0; // level last driven onto the pin
    // remember the driven level while the timer owns the pin
    always @(posedge pclk) begin
        if (oe) last_q <= data;
    end
    // released pin shows the inverse of the last driven level
    assign pin = oe ? data : ~last_q;
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
// bench for the wide timer: apb tasks, pin period checks
// assumes: wtp_top and the pin model compiled first
`default_nettype none
`include "wtp_regs.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, er, wa, oea, wb, oeb, pin_a, pin_b;
    int          error_cnt = 0, num_checks = 0, cyc = 0, i, s;
    ////////////////////////////////////////////////////////////////
    wtp_top wtp_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .primary_wave_output(wa), .primary_wave_oe(oea),
        .channel_wave_output(wb), .channel_wave_oe(oeb));
    wtp_pin_model wtp_pin_model_inst (.pclk(pclk), .oe(oea), .data(wa), .pin(pin_a));
    wtp_pin_model wtp_pin_model_inst_b (.pclk(pclk), .oe(oeb), .data(wb), .pin(pin_b));
    // 40 mhz clock
    always #12.5 pclk = ~pclk;
    // hang guard
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt++;
            $display("mismatch at %0t: timeout", $time);
            give_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // one apb transfer, setup then access until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // wait for the answer; only the hang guard ends a stuck wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    // control word, prescaler always divide by one
    function automatic logic [31:0] ctl(input logic [3:0] m, input logic [1:0] aa, ab,
                                        input logic da, db);
        return {18'h0, db, da, 1'b0, 3'h1, ab, aa, m};
    endfunction
    // high time and period between the second and third rise
    task automatic meas(input logic b, input int eh, input int ep);
        int n, r, hi, per;
        logic p, q;
        hi = 0; per = 0; r = 0; q = 1'b1;
        for (n = 0; n < 5000 && r < 3; n++) begin
            @(posedge pclk);
            #1;
            p = b ? pin_b : pin_a;
            if (p === 1'b1 && q === 1'b0) r++;
            if (r == 2) begin
                per++;
                hi += int'(p === 1'b1);
            end
            q = p;
        end
        chk(hi, eh);
        chk(per, ep);
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (5) @(posedge pclk);
        rdchk(`WTP_OFS_COUNT, 32'h0);
        apb(1'b0, 8'h1C, 32'h0);
        chk({er, rd}, {1'b1, 32'h0});
        // clear on primary compare, toggle
        apb(1'b1, `WTP_OFS_CMPA, 32'h9);
        apb(1'b1, `WTP_OFS_CTRL, ctl(4'h4, 2'h1, 2'h0, 1'b1, 1'b0));
        meas(1'b0, 10, 20);
        rdchk(`WTP_OFS_FLAGS, 32'h6);
        apb(1'b1, `WTP_OFS_FLAGS, 32'hF);
        apb(1'b1, `WTP_OFS_COUNT, 32'hFFF0);
        repeat (40) @(posedge pclk);
        apb(1'b0, `WTP_OFS_FLAGS, 32'h0);
        chk(rd[0], 1'b1);
        // divide by eight stretches the ctc toggle period
        apb(1'b1, `WTP_OFS_CTRL, ctl(4'h4, 2'h1, 2'h0, 1'b1, 1'b0) ^ 32'h300);
        meas(1'b0, 80, 160);
        // direction off hides the wave
        apb(1'b1, `WTP_OFS_CTRL, ctl(4'h4, 2'h1, 2'h0, 1'b0, 1'b0));
        @(posedge pclk);
        #1 chk({oea, wa}, 2'b00);
        // action zero leaves the level alone
        apb(1'b1, `WTP_OFS_CTRL, ctl(4'h4, 2'h0, 2'h0, 1'b1, 1'b0));
        apb(1'b0, `WTP_OFS_STAT, 32'h0);
        s = int'(rd[0]);
        repeat (30) @(posedge pclk);
        apb(1'b0, `WTP_OFS_STAT, 32'h0);
        chk(rd[0], s[0]);
        // clear on capture register
        apb(1'b1, `WTP_OFS_CTRL, ctl(4'hC, 2'h1, 2'h0, 1'b1, 1'b0));
        apb(1'b1, `WTP_OFS_CAPT, 32'h4);
        apb(1'b1, `WTP_OFS_CMPA, 32'h2);
        apb(1'b1, `WTP_OFS_COUNT, 32'h0);
        meas(1'b0, 5, 10);
        // fixed tops: masking, duty, period
        for (i = 0; i < 3; i++) begin
            apb(1'b1, `WTP_OFS_CTRL, ctl(4'(5 + i), 2'h2, 2'h0, 1'b1, 1'b0));
            apb(1'b1, `WTP_OFS_CMPA, 32'h1234);
            apb(1'b1, `WTP_OFS_COUNT, 32'h0);
            rdchk(`WTP_OFS_CMPA, 32'h1234 & ((256 << i) - 1));
            apb(1'b1, `WTP_OFS_CMPB, 32'h1234);
            rdchk(`WTP_OFS_CMPB, 32'h1234 & ((256 << i) - 1));
            meas(1'b0, (256 << i) - 1 - (32'h1234 & ((256 << i) - 1)), 256 << i);
        end
        // capture top of 3, plain on primary and inverted on channel
        apb(1'b1, `WTP_OFS_CTRL, ctl(4'hE, 2'h3, 2'h2, 1'b1, 1'b1));
        apb(1'b1, `WTP_OFS_CAPT, 32'h3);
        apb(1'b1, `WTP_OFS_CMPA, 32'h2);
        apb(1'b1, `WTP_OFS_CMPB, 32'h1);
        apb(1'b1, `WTP_OFS_COUNT, 32'h0);
        // clear stale flags so the top flags below are fresh
        apb(1'b1, `WTP_OFS_FLAGS, 32'hF);
        chk(oeb, 1'b1);
        meas(1'b0, 3, 4);
        meas(1'b1, 2, 4);
        rdchk(`WTP_OFS_FLAGS, 32'hF);
        // compare at top holds a constant level
        apb(1'b1, `WTP_OFS_CMPB, 32'h3);
        repeat (12) @(posedge pclk);
        for (i = 0; i < 8; i++) begin
            @(posedge pclk);
            #1 chk(pin_b, 1'b1);
        end
        // primary compare as top, toggle, buffered update
        apb(1'b1, `WTP_OFS_CMPA, 32'h7);
        apb(1'b1, `WTP_OFS_CTRL, ctl(4'hF, 2'h1, 2'h0, 1'b1, 1'b0));
        apb(1'b1, `WTP_OFS_COUNT, 32'h0);
        meas(1'b0, 8, 16);
        apb(1'b1, `WTP_OFS_CMPA, 32'h3);
        meas(1'b0, 4, 8);
        give_verdict();
    end
endmodule
`default_nettype wire
